// [asp_consts.vh]
// constants for the asynchronous serial port with infrared mode
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
// register indices; byte address is four times the index
`define ASP_IDX_STATUS 16'h4100
`define ASP_IDX_TX_DATA 16'h4101
`define ASP_IDX_RX_DATA 16'h4102
`define ASP_IDX_MODE 16'h4103
`define ASP_IDX_CONTROL 16'h4104
`define ASP_IDX_IR_CFG 16'h4105
// status bit positions
`define ASP_ST_FER 6
`define ASP_ST_PER 5
`define ASP_ST_OER 4
`define ASP_ST_R2B 3
`define ASP_ST_BUSY 2
`define ASP_ST_RRDY 1
`define ASP_ST_TEMPTY 0
// mode bit positions
`define ASP_MD_LEN8 4
`define ASP_MD_PAR 3
`define ASP_MD_ODD 2
`define ASP_MD_STOP2 1
`define ASP_MD_EXTCLK 0
// control bit positions
`define ASP_CT_ERRIE 6
`define ASP_CT_FULLIE 5
`define ASP_CT_EMPTIE 4
`define ASP_CT_THR2 1
`define ASP_CT_EN 0
// infrared config fields
`define ASP_IR_DIV_HI 6
`define ASP_IR_DIV_LO 4
`define ASP_IR_ON 0
// writable masks and reset values
`define ASP_MODE_MASK 8'h1F
`define ASP_CTRL_MASK 8'h73
`define ASP_IRCF_MASK 8'h71
`define ASP_REG_RESET 8'h00
// oversampling and infrared pulse timing, in sample ticks
`define ASP_OVERSAMPLE 5'h10
`define ASP_MID_SAMPLE 4'h7
`define ASP_IR_PULSE 4'h3
`define ASP_IR_STRETCH 5'h10
`endif

// [asp_serial_port.v]
// asynchronous serial port with infrared pulse mode, avalon-mm registers
`timescale 1ns/100ps
`include "asp_consts.vh"

module asp_serial_port (
  input wire core_clk,
  input wire rst_n,
  input wire [15:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire presc_tick,
  input wire ext_clk_pin,
  input wire rxd_pin,
  output reg txd_pin,
  output reg rx_error_irq,
  output reg rx_full_irq,
  output reg tx_empty_irq
);

  // receiver states
  localparam RX_IDLE = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA = 3'd2;
  localparam RX_PAR = 3'd3;
  localparam RX_STOP = 3'd4;

  // parity of the data bits that go on the line
  function par_of;
    input [7:0] d;
    input len8;
    input odd;
    begin
      par_of = (len8 ? ^d : ^d[6:0]) ^ odd;
    end
  endfunction

  reg [7:0] mode_reg; // frame format
  reg [7:0] ctrl_reg; // enables and threshold
  reg [7:0] ircf_reg; // infrared settings
  reg fer_reg, per_reg, oer_reg; // sticky receive errors
  reg [7:0] txbuf_reg; // transmit holding byte
  reg txfull_reg; // holding byte not yet loaded
  // synchronisers for the pins
  reg rx_s1_reg, rx_s2_reg, ck_s1_reg, ck_s2_reg, ck_d_reg;
  // two-entry receive buffer
  reg [7:0] fifo_mem [0:1];
  reg wptr_reg, rptr_reg;
  reg [1:0] cnt_reg;
  // transmitter
  reg [11:0] tsh_reg; // frame bits, lsb first
  reg [3:0] tleft_reg; // bits still to send
  reg [3:0] ttick_reg; // sample ticks within a bit
  // receiver
  reg [2:0] rst_reg;
  reg [3:0] rtick_reg;
  reg [3:0] rbits_reg;
  reg [7:0] rsh_reg;
  reg rpx_reg; // running parity of received bits
  // infrared detection
  reg [7:0] irdiv_reg;
  reg [4:0] irhold_reg;
  reg ack_reg; // bus answer given this cycle

  wire en = ctrl_reg[`ASP_CT_EN];
  wire len8 = mode_reg[`ASP_MD_LEN8];
  wire ir_on = ircf_reg[`ASP_IR_ON];
  // oversample tick from internal prescaler or external pin rise
  wire ext_rise = ck_s2_reg & ~ck_d_reg;
  wire tick = en & (mode_reg[`ASP_MD_EXTCLK] ? ext_rise : presc_tick);
  wire busy = (tleft_reg != 4'h0);
  wire acc = avs_read | avs_write;
  wire do_wr = avs_write & ack_reg; // write lands at the answer edge
  wire do_rd = avs_read & ack_reg;
  wire [2:0] irsel = ircf_reg[`ASP_IR_DIV_HI:`ASP_IR_DIV_LO];
  // detect tick: peripheral clock divided by two to the code
  wire [7:0] irmask = (8'h01 << irsel) - 8'h01;
  wire irtick = ((irdiv_reg & irmask) == 8'h00);
  // receive line as seen by the framer
  wire rx_line = ir_on ? (irhold_reg == 5'h00) : rx_s2_reg;
  wire push = (rst_reg == RX_STOP) & tick & (rtick_reg == 4'hF) & rx_line;
  wire push_ready = (cnt_reg != 2'd2);
  wire pop = do_rd & (avs_address == `ASP_IDX_RX_DATA) & (cnt_reg != 2'd0);
  wire [7:0] status = {1'b0, fer_reg, per_reg, oer_reg,
    (cnt_reg == 2'd2), busy, (cnt_reg != 2'd0), ~txfull_reg};
  // status comes straight from flags

  // bus slave: one wait cycle, then answer for a single cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= acc & ~ack_reg;
      avs_waitrequest <= ~(acc & ~ack_reg);
      if (avs_read & ~ack_reg) begin
        case (avs_address)
          `ASP_IDX_STATUS: avs_readdata <= {24'h000000, status};
          `ASP_IDX_TX_DATA: avs_readdata <= {24'h000000, txbuf_reg};
          `ASP_IDX_RX_DATA: begin
            // oldest byte first; empty reads zero
            if (cnt_reg != 2'd0) begin
              avs_readdata <= {24'h000000, fifo_mem[rptr_reg]};
            end else begin
              avs_readdata <= 32'h00000000;
            end
          end
          `ASP_IDX_MODE: avs_readdata <= {24'h000000, mode_reg};
          `ASP_IDX_CONTROL: avs_readdata <= {24'h000000, ctrl_reg};
          `ASP_IDX_IR_CFG: avs_readdata <= {24'h000000, ircf_reg};
          default: avs_readdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // configuration registers; reserved bits masked off
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `ASP_REG_RESET;
      ctrl_reg <= `ASP_REG_RESET; // port starts disabled
      ircf_reg <= `ASP_REG_RESET;
    end else if (do_wr) begin
      if (avs_address == `ASP_IDX_MODE) begin
        mode_reg <= avs_writedata[7:0] & `ASP_MODE_MASK;
      end
      if (avs_address == `ASP_IDX_CONTROL) begin
        ctrl_reg <= avs_writedata[7:0] & `ASP_CTRL_MASK;
      end
      if (avs_address == `ASP_IDX_IR_CFG) begin
        ircf_reg <= avs_writedata[7:0] & `ASP_IRCF_MASK;
      end
    end
  end

  // pin synchronisers; first stage feeds only the second
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_d_reg <= 1'b0;
    end else begin
      rx_s1_reg <= rxd_pin;
      rx_s2_reg <= rx_s1_reg;
      ck_s1_reg <= ext_clk_pin;
      ck_s2_reg <= ck_s1_reg;
      ck_d_reg <= ck_s2_reg;
    end
  end

  // error flags: hardware set wins over a write-one clear
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fer_reg <= 1'b0;
      per_reg <= 1'b0;
      oer_reg <= 1'b0;
    end else begin
      if (do_wr && avs_address == `ASP_IDX_STATUS) begin
        if (avs_writedata[`ASP_ST_FER]) fer_reg <= 1'b0;
        if (avs_writedata[`ASP_ST_PER]) per_reg <= 1'b0;
        if (avs_writedata[`ASP_ST_OER]) oer_reg <= 1'b0;
      end
      if ((rst_reg == RX_STOP) && tick && rtick_reg == 4'hF) begin
        if (!rx_line) fer_reg <= 1'b1; // bad stop bit
        if (mode_reg[`ASP_MD_PAR] && rpx_reg != mode_reg[`ASP_MD_ODD]) begin
          per_reg <= 1'b1;
        end
        if (rx_line && !push_ready) oer_reg <= 1'b1; // byte lost
      end
    end
  end

  // receive buffer: framer fills, software read drains
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg <= 2'd0;
      fifo_mem[0] <= 8'h00;
      fifo_mem[1] <= 8'h00;
    end else begin
      if (push && push_ready) begin
        fifo_mem[wptr_reg] <= rsh_reg;
        wptr_reg <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push & push_ready} - {1'b0, pop};
    end
  end

  // transmit holding byte and its empty flag
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_reg <= 8'h00;
      txfull_reg <= 1'b0; // reads empty after reset
    end else begin
      if (en && !busy && txfull_reg) begin
        txfull_reg <= 1'b0; // moved to shifter
      end
      if (do_wr && avs_address == `ASP_IDX_TX_DATA) begin
        txbuf_reg <= avs_writedata[7:0];
        txfull_reg <= 1'b1; // a new write wins
      end
    end
  end

  // transmit shifter: builds the whole frame at load time
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tsh_reg <= 12'hFFF;
      tleft_reg <= 4'h0;
      ttick_reg <= 4'h0;
    end else if (!en) begin
      tleft_reg <= 4'h0; // disable aborts the frame
      tsh_reg <= 12'hFFF;
    end else if (!busy) begin
      ttick_reg <= 4'h0;
      if (txfull_reg) begin
        // start, data, optional parity, then stop ones
        if (len8) begin
          tsh_reg <= mode_reg[`ASP_MD_PAR] ?
            {2'b11, par_of(txbuf_reg, 1'b1, mode_reg[`ASP_MD_ODD]),
             txbuf_reg, 1'b0} :
            {3'b111, txbuf_reg, 1'b0};
        end else begin
          tsh_reg <= mode_reg[`ASP_MD_PAR] ?
            {3'b111, par_of(txbuf_reg, 1'b0, mode_reg[`ASP_MD_ODD]),
             txbuf_reg[6:0], 1'b0} :
            {4'b1111, txbuf_reg[6:0], 1'b0};
        end
        // bit count
        tleft_reg <= 4'h3 + {3'b000, len8} + 4'h6 +
          {3'b000, mode_reg[`ASP_MD_PAR]} + {3'b000, mode_reg[`ASP_MD_STOP2]};
      end
    end else if (tick) begin
      ttick_reg <= ttick_reg + 4'h1;
      if (ttick_reg == 4'hF) begin
        tsh_reg <= {1'b1, tsh_reg[11:1]};
        tleft_reg <= tleft_reg - 4'h1;
      end
    end
  end

  // line driver: plain level or short high pulse for a zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_pin <= 1'b1;
    end else if (ir_on) begin
      txd_pin <= busy & ~tsh_reg[0] & (ttick_reg < `ASP_IR_PULSE);
    end else begin
      txd_pin <= busy ? tsh_reg[0] : 1'b1;
    end
  end

  // infrared detection: sample the pin on the divided clock and
  // stretch each low pulse to a full bit time
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irdiv_reg <= 8'h00;
      irhold_reg <= 5'h00;
    end else begin
      irdiv_reg <= irdiv_reg + 8'h01;
      if (ir_on && irtick && !rx_s2_reg) begin
        irhold_reg <= `ASP_IR_STRETCH;
      end else if (tick && irhold_reg != 5'h00) begin
        irhold_reg <= irhold_reg - 5'h01;
      end
    end
  end

  // receive framer: mid-bit sampling on the oversample tick
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_reg <= RX_IDLE;
      rtick_reg <= 4'h0;
      rbits_reg <= 4'h0;
      rsh_reg <= 8'h00;
      rpx_reg <= 1'b0;
    end else if (!en) begin
      rst_reg <= RX_IDLE; // disabled port ignores the line
    end else if (tick) begin
      rtick_reg <= rtick_reg + 4'h1;
      case (rst_reg)
        RX_IDLE: begin
          rtick_reg <= 4'h0;
          if (!rx_line) rst_reg <= RX_START;
        end
        RX_START: begin
          // re-centre on the middle of the start bit; glitch rejected
          if (rtick_reg == `ASP_MID_SAMPLE) begin
            rtick_reg <= 4'h0;
            rbits_reg <= 4'h0;
            rpx_reg <= 1'b0;
            rst_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rtick_reg == 4'hF) begin
            // seven-bit bytes land in bits 6:0
            rsh_reg <= len8 ? {rx_line, rsh_reg[7:1]} :
              {1'b0, rx_line, rsh_reg[6:1]};
            rpx_reg <= rpx_reg ^ rx_line;
            rbits_reg <= rbits_reg + 4'h1;
            if (rbits_reg == (len8 ? 4'h7 : 4'h6)) begin
              rst_reg <= mode_reg[`ASP_MD_PAR] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rtick_reg == 4'hF) begin
            rpx_reg <= rpx_reg ^ rx_line;
            rst_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // only the first stop bit is checked
          if (rtick_reg == 4'hF) rst_reg <= RX_IDLE;
        end
        default: rst_reg <= RX_IDLE;
      endcase
    end
  end

  // interrupt request levels
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_error_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
    end else begin
      rx_error_irq <= ctrl_reg[`ASP_CT_ERRIE] &
        (fer_reg | per_reg | oer_reg);
      rx_full_irq <= ctrl_reg[`ASP_CT_FULLIE] &
        (ctrl_reg[`ASP_CT_THR2] ? (cnt_reg == 2'd2) :
         (cnt_reg != 2'd0));
      tx_empty_irq <= ctrl_reg[`ASP_CT_EMPTIE] & ~txfull_reg;
    end
  end

endmodule // asp_serial_port

// [asp_serial_port_monitor.sv]
// checker: bus answer, register readback, irq gating, line idle
`timescale 1ns/100ps
`include "asp_consts.vh"
module asp_monitor (
  input logic core_clk,
  input logic rst_n,
  input logic [15:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic presc_tick,
  input logic ext_clk_pin,
  input logic rxd_pin,
  input logic txd_pin,
  input logic rx_error_irq,
  input logic rx_full_irq,
  input logic tx_empty_irq
);
  logic [7:0] mode_q, ctrl_q, ctrl_p, ir_q, ir_p; // register shadows
  logic en_pp; // enable one cycle later still: an abort needs two edges
  wire req = avs_read | avs_write; // request raised
  wire wr_ok = avs_write & ~avs_waitrequest; // write lands here
  wire rd_ok = avs_read & ~avs_waitrequest; // read data stand
  wire bad = avs_address < 16'h4100 || avs_address > 16'h4105;
  // shadows follow writes at the answer edge; _p lags one cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      ctrl_p <= 8'h00;
      ir_q <= 8'h00;
      ir_p <= 8'h00;
      en_pp <= 1'b0;
    end else begin
      ctrl_p <= ctrl_q;
      ir_p <= ir_q;
      en_pp <= ctrl_p[0];
      if (wr_ok && avs_address == `ASP_IDX_MODE)
        mode_q <= avs_writedata[7:0] & `ASP_MODE_MASK;
      if (wr_ok && avs_address == `ASP_IDX_CONTROL)
        ctrl_q <= avs_writedata[7:0] & `ASP_CTRL_MASK;
      if (wr_ok && avs_address == `ASP_IDX_IR_CFG)
        ir_q <= avs_writedata[7:0] & `ASP_IRCF_MASK;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // answer: one low cycle, then busy again
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (req && avs_waitrequest |=> s_answer)
    else $error("answer not one cycle");
  AST_HIGH_ZERO: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (rd_ok && bad |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_ST_RSVD: assert property
    (rd_ok && avs_address == `ASP_IDX_STATUS |-> !avs_readdata[7])
    else $error("status bit 7 set");
  AST_MODE_BACK: assert property
    (rd_ok && avs_address == `ASP_IDX_MODE |-> avs_readdata[7:0] == mode_q)
    else $error("mode readback wrong");
  AST_CTRL_BACK: assert property
    (rd_ok && avs_address == `ASP_IDX_CONTROL |-> avs_readdata[7:0] == ctrl_q)
    else $error("control readback wrong");
  AST_IR_BACK: assert property
    (rd_ok && avs_address == `ASP_IDX_IR_CFG |-> avs_readdata[7:0] == ir_q)
    else $error("infrared readback wrong");
  AST_ERR_GATE: assert property (!ctrl_q[6] && !ctrl_p[6] |-> !rx_error_irq)
    else $error("error irq while masked");
  AST_FULL_GATE: assert property (!ctrl_q[5] && !ctrl_p[5] |-> !rx_full_irq)
    else $error("full irq while masked");
  AST_EMPTY_GATE: assert property
    (!ctrl_q[4] && !ctrl_p[4] |-> !tx_empty_irq)
    else $error("empty irq while masked");
  AST_TXD_IDLE: assert property
    (!ctrl_q[0] && !ctrl_p[0] && !en_pp && !ir_q[0] && !ir_p[0] |-> txd_pin)
    else $error("line active while disabled");
endmodule // asp_monitor
bind asp_serial_port asp_monitor u_mon (.core_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .presc_tick, .ext_clk_pin, .rxd_pin, .txd_pin, .rx_error_irq,
  .rx_full_irq, .tx_empty_irq);

// [asp_peer.sv]
// remote serial peer: sends raw frames, captures 8-bit frames
`timescale 1ns/100ps
module asp_peer #(
  parameter int BITC = 32
) (
  input logic clk,
  input logic txd,
  output logic rxd
);
  logic [7:0] got[$]; // bytes seen on the port's transmit line
  logic [7:0] sh; // capture shift register
  initial rxd = 1'b1; // plain line idles high
  // raw frame bits lsb first, so tests can break stop or parity
  task automatic send(input logic [11:0] fr, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= fr[i];
      repeat (BITC) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // sample mid-bit; no stop check, the port is the one under test
  always begin
    @(negedge txd);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BITC) @(posedge clk);
    got.push_back(sh);
  end
endmodule // asp_peer

// [tb_async_serial_port_infrared.sv]
// testbench for the serial port: registers, frames, flags, irqs
`timescale 1ns/100ps
`include "asp_consts.vh"
module tb_async_serial_port_infrared;
  logic core_clk, rst_n, avs_read, avs_write, presc_tick, ext_clk_pin;
  logic presc_run; // prescaler ticking; low hands the tick to the pin
  logic [15:0] avs_address;
  logic [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rxd_pin, txd_pin;
  wire rx_error_irq, rx_full_irq, tx_empty_irq;
  logic [7:0] d; // last read value
  int err_total, check_count, cyc;
  // rows: {index, write value, expected readback}
  logic [31:0] rows [10] = '{32'h4103FF1F, 32'h41030000, 32'h4104FF73,
    32'h41040000, 32'h4105FF71, 32'h41050000, 32'h4102FF00,
    32'h4106FF00, 32'h410FFF00, 32'h4100FF01};
  asp_serial_port dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .presc_tick(presc_tick), .ext_clk_pin(ext_clk_pin),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .rx_error_irq(rx_error_irq),
    .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq));
  asp_peer #(.BITC(32)) u_peer (.clk(core_clk), .txd(txd_pin),
    .rxd(rxd_pin));
  always #20 core_clk = ~core_clk;
  // tick every other cycle: 32 clocks per bit; the pin clock runs
  // only while the prescaler is parked, so the source choice shows
  always @(posedge core_clk) presc_tick <= presc_run & ~presc_tick;
  always @(posedge core_clk) ext_clk_pin <= ~presc_run & ~ext_clk_pin;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // hold request until waitrequest is sampled low
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    core_clk = 0;
    rst_n = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 16'h0;
    avs_writedata = 32'h0;
    presc_tick = 0;
    ext_clk_pin = 0;
    presc_run = 1;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h01);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], d);
      chk(d, rows[i][7:0]);
    end
    // the pulse-mode row drops the line; let that capture run out
    repeat (320) @(posedge core_clk);
    // back-to-back transmit: second byte waits behind the shifter
    u_peer.got.delete();
    wr(`ASP_IDX_MODE, 8'h10);
    wr(`ASP_IDX_CONTROL, 8'h11);
    wr(`ASP_IDX_TX_DATA, 8'hA5);
    wr(`ASP_IDX_TX_DATA, 8'h3C);
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h04);
    chk({7'h0, tx_empty_irq}, 8'h00);
    for (int k = 0; k < 400 && d !== 8'h01; k++) rd(`ASP_IDX_STATUS, d);
    chk(d, 8'h01);
    repeat (40) @(posedge core_clk);
    chk({7'h0, tx_empty_irq}, 8'h01);
    chk(u_peer.got[0], 8'hA5);
    chk(u_peer.got[1], 8'h3C);
    // receive three bytes into a two-byte buffer
    wr(`ASP_IDX_CONTROL, 8'h23);
    u_peer.send({3'h7, 8'h5A, 1'b0}, 10);
    chk({7'h0, rx_full_irq}, 8'h00);
    u_peer.send({3'h7, 8'hC3, 1'b0}, 10);
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h0B);
    chk({7'h0, rx_full_irq}, 8'h01);
    u_peer.send({3'h7, 8'h77, 1'b0}, 10);
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h1B);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'h5A);
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h13);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'hC3);
    wr(`ASP_IDX_STATUS, 8'h10);
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h01);
    // stop bit held low: framing error and its irq
    wr(`ASP_IDX_CONTROL, 8'h41);
    u_peer.send({3'h6, 8'h81, 1'b0}, 10);
    rd(`ASP_IDX_STATUS, d); chk(d & 8'h40, 8'h40);
    chk({7'h0, rx_error_irq}, 8'h01);
    wr(`ASP_IDX_STATUS, 8'h40);
    rd(`ASP_IDX_STATUS, d); chk(d & 8'h40, 8'h00);
    chk({7'h0, rx_error_irq}, 8'h00);
    rd(`ASP_IDX_RX_DATA, d);
    // even parity with wrong bit, then odd parity accepted
    wr(`ASP_IDX_MODE, 8'h18);
    u_peer.send({2'h3, 1'b0, 8'h01, 1'b0}, 11);
    rd(`ASP_IDX_STATUS, d); chk(d & 8'h20, 8'h20);
    wr(`ASP_IDX_STATUS, 8'h20);
    rd(`ASP_IDX_RX_DATA, d);
    wr(`ASP_IDX_MODE, 8'h1C);
    u_peer.send({2'h3, 1'b0, 8'h01, 1'b0}, 11);
    rd(`ASP_IDX_STATUS, d); chk(d & 8'h20, 8'h00);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'h01);
    // seven-bit character
    wr(`ASP_IDX_MODE, 8'h00);
    u_peer.send({4'hF, 7'h55, 1'b0}, 9);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'h55);
    // pin clock with the prescaler parked; one-byte full threshold
    wr(`ASP_IDX_CONTROL, 8'h21);
    wr(`ASP_IDX_MODE, 8'h11);
    chk({7'h0, rx_full_irq}, 8'h00);
    presc_run <= 1'b0;
    u_peer.send({3'h7, 8'h96, 1'b0}, 10);
    chk({7'h0, rx_full_irq}, 8'h01);
    rd(`ASP_IDX_RX_DATA, d); chk(d, 8'h96);
    presc_run <= 1'b1;
    // pulse mode idles low; then reset mid-run
    wr(`ASP_IDX_IR_CFG, 8'h71);
    repeat (4) @(posedge core_clk);
    chk({7'h0, txd_pin}, 8'h00);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`ASP_IDX_STATUS, d); chk(d, 8'h01);
    rd(`ASP_IDX_IR_CFG, d); chk(d, 8'h00);
    wrap_up();
  end
endmodule // tb_async_serial_port_infrared
